//--- include/host_power_watchdog_params.svh
`ifndef HOST_POWER_WATCHDOG_PARAMS_SVH
`define HOST_POWER_WATCHDOG_PARAMS_SVH
// wishbone byte offsets
`define OFS_CMD 8'h00
`define OFS_REPLY 8'h04
`define OFS_STATUS 8'h08
`define OFS_RB_BASE 8'h40
`define RB_LAST 4'hE
// command and reply type codes
`define TYPE_FUNC 8'h1C
`define TYPE_WDOG 8'h1D
`define TYPE_RDSTAT 8'h1E
`define REPLY_BIT 8'h40
`define REPLY_BAD 8'hFF
`define RB_LEN 8'h0F
`define RB_IDX_MASK 4'h7
`define RB_IDX_WDOG 4'h8
// function mask bit positions
`define FN_AUTO 0
`define FN_RST_INV 1
`define FN_PWR_INV 2
`define FN_BLANK 4
`define FN_KEY_RST 5
`define FN_KEY_PON 6
`define FN_KEY_POFF 7
// cmd register fields
`define CMD_TYPE_LSB 0
`define CMD_D0_LSB 8
`define CMD_D1_LSB 16
`define CMD_LEN_LSB 24
// reset values
`define FUNC_RST 8'h00
`define PLEN_RST 8'h20
`define PLEN_HOLD 8'hFF
// timing
`define CLK_HZ 125000000
`define TICK_HZ 32
`define TICK_CYC (`CLK_HZ / `TICK_HZ)
`define HOLD_LONG_MS 4000
`define HOLD_SHORT_MS 250
`define RST_PULSE_MS 1000
`define EXTRA_MS 5000
`define RELEASE_SETTLE 3'h4
`define MS_TO_TICKS(ms) (((ms) * `TICK_HZ) / 1000)
`endif

//--- include/host_power_watchdog_pkg.sv
package host_power_watchdog_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RST_PULSE = 3'h1,
    ST_PWR_PULSE = 3'h3,
    ST_PWR_EXTRA = 3'h2,
    ST_REBOOT = 3'h6
  } state_t;
  typedef enum logic [1:0] {
    WHY_KEY_RST = 2'h0,
    WHY_WDOG = 2'h1,
    WHY_PON = 2'h2,
    WHY_POFF = 2'h3
  } why_t;
  typedef enum logic [1:0] {
    MSG_NONE = 2'h0,
    MSG_RESET = 2'h1,
    MSG_POWER_ON = 2'h2,
    MSG_POWER_OFF = 2'h3
  } msg_t;
endpackage

//--- verilog/host_power_watchdog_ctrl.sv
`timescale 1ns/100ps
`include "host_power_watchdog_params.svh"
`default_nettype none
module host_power_watchdog_ctrl #(
  parameter int TICK_CYC = `TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic sense_i,
  input wire logic key_ur_i,
  input wire logic key_lr_i,
  input wire logic pwr_i,
  output logic pwr_o,
  output logic pwr_oe_o,
  input wire logic rst_line_i,
  output logic rst_line_o,
  output logic rst_line_oe_o,
  output logic display_blank_o,
  output logic backlight_off_o,
  output logic [1:0] message_o,
  output logic reboot_o
);
  localparam logic [7:0] HOLD_LONG = 8'(`MS_TO_TICKS(`HOLD_LONG_MS));
  localparam logic [7:0] HOLD_SHORT = 8'(`MS_TO_TICKS(`HOLD_SHORT_MS));
  localparam logic [7:0] RST_TICKS = 8'(`MS_TO_TICKS(`RST_PULSE_MS));
  localparam logic [7:0] EXTRA_TICKS = 8'(`MS_TO_TICKS(`EXTRA_MS));
  localparam logic [4:0] TICKS_PER_SEC = 5'(`TICK_HZ - 1);

  function automatic logic [7:0] rb_byte(input logic [3:0] idx, input logic [7:0] fm,
                                         input logic [7:0] wd);
    rb_byte = 8'h00;
    if (idx == `RB_IDX_MASK) begin
      rb_byte = fm;
    end else if (idx == `RB_IDX_WDOG) begin
      rb_byte = wd;
    end
  endfunction

  // pin synchronisers
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  always_ff @(posedge clk_i) begin
    sync_a <= {sense_i, key_ur_i, key_lr_i, pwr_i, rst_line_i};
    sync_b <= sync_a;
  end
  wire sense = sync_b[4];
  wire key_ur = sync_b[3];
  wire key_lr = sync_b[2];
  wire pwr_s = sync_b[1];
  wire rst_s = sync_b[0];

  // 1/32 s tick
  logic [31:0] div_cnt;
  wire tick = (div_cnt == 32'(TICK_CYC - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      div_cnt <= 32'h0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end

  host_power_watchdog_pkg::state_t state;
  host_power_watchdog_pkg::state_t next_state;
  host_power_watchdog_pkg::why_t why;
  logic [7:0] func_mask;
  logic [7:0] plen;
  logic [7:0] wd_cnt;
  logic [4:0] wd_sub;
  logic [7:0] hold_cnt;
  logic [7:0] pcnt;
  logic sense_d;
  logic sense_at_start;
  logic idle_pwr;
  logic idle_rst;
  logic [7:0] rep_type;
  logic [7:0] rep_len;
  logic rep_valid;
  logic wd_pend;
  logic [2:0] pwr_free;
  logic [2:0] rst_free;

  // bus decode
  wire req = cyc_i & stb_i & ~ack_o;
  wire wr_cmd = req & we_i & (adr_i == `OFS_CMD) & (&sel_i);
  wire rd_reply = req & ~we_i & (adr_i == `OFS_REPLY);
  wire [3:0] rb_idx = adr_i[5:2];
  wire rb_hit = (adr_i[7:6] == 2'h1) & (adr_i[1:0] == 2'h0) & (rb_idx <= `RB_LAST);
  wire locked = (state == host_power_watchdog_pkg::ST_REBOOT);
  wire cmd_ok = wr_cmd & ~locked;
  wire [7:0] c_type = dat_i[`CMD_TYPE_LSB +: 8];
  wire [7:0] c_d0 = dat_i[`CMD_D0_LSB +: 8];
  wire [7:0] c_d1 = dat_i[`CMD_D1_LSB +: 8];
  wire [1:0] c_len = dat_i[`CMD_LEN_LSB +: 2];
  wire func_ok = (c_type == `TYPE_FUNC) & ((c_len == 2'h1) | (c_len == 2'h2));
  wire wdog_ok = (c_type == `TYPE_WDOG) & (c_len == 2'h1);
  wire stat_ok = (c_type == `TYPE_RDSTAT) & (c_len == 2'h0);

  wire [31:0] status_word = {3'h0, locked, display_blank_o, pwr_oe_o, rst_line_oe_o,
                             sense, wd_cnt, plen, func_mask};
  wire [31:0] reply_word = {15'h0, rep_valid, rep_len, rep_type};
  wire [31:0] rdata = (adr_i == `OFS_REPLY) ? reply_word :
                      (adr_i == `OFS_STATUS) ? status_word :
                      rb_hit ? {24'h0, rb_byte(rb_idx, func_mask, wd_cnt)} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= req;
      if (req) begin
        dat_o <= we_i ? 32'h0 : rdata;
      end
    end
  end

  // configuration and replies
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      func_mask <= `FUNC_RST;
      plen <= `PLEN_RST;
      rep_type <= 8'h00;
      rep_len <= 8'h00;
      rep_valid <= 1'b0;
    end else begin
      if (cmd_ok) begin
        rep_valid <= 1'b1;
        rep_len <= stat_ok ? `RB_LEN : 8'h00;
        rep_type <= (func_ok | wdog_ok | stat_ok) ? (c_type | `REPLY_BIT) : `REPLY_BAD;
        if (func_ok) begin
          func_mask <= c_d0;
          if (c_len == 2'h2 && c_d1 != 8'h00) begin
            plen <= c_d1;
          end
        end
      end else if (rd_reply) begin
        rep_valid <= 1'b0;
      end
    end
  end

  // watchdog, counts whole seconds
  wire sec_tick = tick & (wd_sub == TICKS_PER_SEC);
  wire wd_expire = sec_tick & (wd_cnt == 8'h01);
  always_ff @(posedge clk_i) begin
    if (rst_i || state == host_power_watchdog_pkg::ST_REBOOT) begin
      wd_cnt <= 8'h00;
      wd_sub <= 5'h0;
    end else if (cmd_ok && wdog_ok) begin
      wd_cnt <= c_d0;
      wd_sub <= 5'h0;
    end else if (wd_cnt != 8'h00) begin
      if (tick) begin
        wd_sub <= wd_sub + 5'h1;
      end
      if (sec_tick) begin
        wd_cnt <= wd_cnt - 8'h01;
      end
    end
  end

  // expiry during another pulse waits for idle, but is dropped if that pulse ends in ST_REBOOT
  always_ff @(posedge clk_i) begin
    if (rst_i || state == host_power_watchdog_pkg::ST_REBOOT) begin
      wd_pend <= 1'b0;
    end else if (wd_expire && state != host_power_watchdog_pkg::ST_IDLE) begin
      wd_pend <= 1'b1;
    end else if (state == host_power_watchdog_pkg::ST_IDLE) begin
      wd_pend <= 1'b0;
    end
  end
  wire wd_fire = wd_expire | wd_pend;

  // key hold detection
  wire want_rst = func_mask[`FN_KEY_RST] & sense & key_ur;
  wire want_pon = func_mask[`FN_KEY_PON] & ~sense & key_ur;
  wire want_poff = func_mask[`FN_KEY_POFF] & sense & key_lr & ~key_ur;
  wire want_any = want_rst | want_pon | want_poff;
  wire [7:0] hold_need = want_pon ? HOLD_SHORT : HOLD_LONG;
  wire hold_done = want_any & tick & (hold_cnt + 8'h01 >= hold_need);
  always_ff @(posedge clk_i) begin
    if (rst_i || !want_any || state != host_power_watchdog_pkg::ST_IDLE) begin
      hold_cnt <= 8'h00;
    end else if (tick) begin
      hold_cnt <= hold_cnt + 8'h01;
    end
  end

  wire sense_rise = sense & ~sense_d & func_mask[`FN_BLANK];
  wire pulse_end = (plen == `PLEN_HOLD) ? (sense != sense_at_start) :
                   (tick & (pcnt + 8'h01 >= plen));
  always_comb begin
    next_state = state;
    case (state)
      host_power_watchdog_pkg::ST_IDLE: begin
        if (wd_fire || (hold_done && want_rst)) begin
          next_state = host_power_watchdog_pkg::ST_RST_PULSE;
        end else if (hold_done) begin
          next_state = host_power_watchdog_pkg::ST_PWR_PULSE;
        end else if (sense_rise) begin
          next_state = host_power_watchdog_pkg::ST_REBOOT;
        end
      end
      host_power_watchdog_pkg::ST_RST_PULSE: begin
        if (tick && pcnt + 8'h01 >= RST_TICKS) begin
          next_state = (why == host_power_watchdog_pkg::WHY_KEY_RST) ?
                       host_power_watchdog_pkg::ST_REBOOT : host_power_watchdog_pkg::ST_IDLE;
        end
      end
      host_power_watchdog_pkg::ST_PWR_PULSE: begin
        if (pulse_end) begin
          if (why == host_power_watchdog_pkg::WHY_PON) begin
            next_state = host_power_watchdog_pkg::ST_REBOOT;
          end else if (key_lr && plen != `PLEN_HOLD) begin
            next_state = host_power_watchdog_pkg::ST_PWR_EXTRA;
          end else begin
            next_state = host_power_watchdog_pkg::ST_IDLE;
          end
        end
      end
      host_power_watchdog_pkg::ST_PWR_EXTRA: begin
        if (!key_lr || (tick && pcnt + 8'h01 >= EXTRA_TICKS)) begin
          next_state = host_power_watchdog_pkg::ST_IDLE;
        end
      end
      host_power_watchdog_pkg::ST_REBOOT: begin
        next_state = host_power_watchdog_pkg::ST_IDLE;
      end
      default: begin
        next_state = host_power_watchdog_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= host_power_watchdog_pkg::ST_IDLE;
      why <= host_power_watchdog_pkg::WHY_KEY_RST;
      pcnt <= 8'h00;
      sense_d <= 1'b0;
      sense_at_start <= 1'b0;
    end else begin
      state <= next_state;
      sense_d <= sense;
      if (next_state != state) begin
        pcnt <= 8'h00;
        sense_at_start <= sense;
      end else if (tick) begin
        pcnt <= pcnt + 8'h01;
      end
      if (state == host_power_watchdog_pkg::ST_IDLE && next_state != state) begin
        why <= wd_fire ? host_power_watchdog_pkg::WHY_WDOG :
               want_rst ? host_power_watchdog_pkg::WHY_KEY_RST :
               want_pon ? host_power_watchdog_pkg::WHY_PON : host_power_watchdog_pkg::WHY_POFF;
      end
    end
  end

  // line drive with polarity; idle level sampled only while released
  wire drv_rst = (state == host_power_watchdog_pkg::ST_RST_PULSE);
  wire drv_pwr = (state == host_power_watchdog_pkg::ST_PWR_PULSE) |
                 (state == host_power_watchdog_pkg::ST_PWR_EXTRA);
  wire lvl_rst = func_mask[`FN_AUTO] ? ~idle_rst : func_mask[`FN_RST_INV];
  wire lvl_pwr = func_mask[`FN_AUTO] ? ~idle_pwr : func_mask[`FN_PWR_INV];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_pwr <= 1'b1;
      idle_rst <= 1'b1;
      pwr_free <= 3'h0;
      rst_free <= 3'h0;
      pwr_o <= 1'b0;
      pwr_oe_o <= 1'b0;
      rst_line_o <= 1'b0;
      rst_line_oe_o <= 1'b0;
    end else begin
      // synchronised pin lags the release, so wait before trusting it
      if (pwr_oe_o) begin
        pwr_free <= 3'h0;
      end else if (pwr_free != `RELEASE_SETTLE) begin
        pwr_free <= pwr_free + 3'h1;
      end else begin
        idle_pwr <= pwr_s;
      end
      if (rst_line_oe_o) begin
        rst_free <= 3'h0;
      end else if (rst_free != `RELEASE_SETTLE) begin
        rst_free <= rst_free + 3'h1;
      end else begin
        idle_rst <= rst_s;
      end
      pwr_oe_o <= drv_pwr;
      pwr_o <= drv_pwr & lvl_pwr;
      rst_line_oe_o <= drv_rst;
      rst_line_o <= drv_rst & lvl_rst;
    end
  end

  // display side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      display_blank_o <= 1'b0;
      backlight_off_o <= 1'b0;
      message_o <= host_power_watchdog_pkg::MSG_NONE;
      reboot_o <= 1'b0;
    end else begin
      display_blank_o <= func_mask[`FN_BLANK] & ~sense;
      backlight_off_o <= func_mask[`FN_BLANK] & ~sense;
      reboot_o <= (state == host_power_watchdog_pkg::ST_REBOOT);
      if (drv_rst) begin
        message_o <= host_power_watchdog_pkg::MSG_RESET;
      end else if (drv_pwr) begin
        message_o <= (why == host_power_watchdog_pkg::WHY_PON) ?
                     host_power_watchdog_pkg::MSG_POWER_ON : host_power_watchdog_pkg::MSG_POWER_OFF;
      end else begin
        message_o <= host_power_watchdog_pkg::MSG_NONE;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/host_power_watchdog_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module host_power_watchdog_ctrl_monitor #(
  parameter int TICK_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic pwr_oe_o,
  input wire logic rst_line_o,
  input wire logic rst_line_oe_o,
  input wire logic display_blank_o,
  input wire logic backlight_off_o,
  input wire logic [1:0] message_o,
  input wire logic reboot_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] hi_cnt;
  // cycles the reset line has been driven
  always_ff @(posedge clk_i) begin
    if (rst_i || !rst_line_oe_o) hi_cnt <= 32'h0;
    else hi_cnt <= hi_cnt + 32'h1;
  end
  ack_pulse_a: assert property (
    ack_o |=> !ack_o) else $error("ack longer than one cycle");
  ack_resp_a: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack after request");
  wr_zero_a: assert property (
    ack_o && $past(we_i) |-> dat_o == 32'h0) else $error("write ack data not zero");
  blank_pair_a: assert property (
    display_blank_o == backlight_off_o) else $error("blank and backlight differ");
  oe_excl_a: assert property (
    !(pwr_oe_o && rst_line_oe_o)) else $error("both lines driven");
  rst_len_a: assert property (
    $fell(rst_line_oe_o) |-> hi_cnt >= 31 * TICK_CYC && hi_cnt <= 33 * TICK_CYC)
    else $error("reset pulse length wrong");
  rst_level_a: assert property (
    rst_line_oe_o && $past(rst_line_oe_o) |-> $stable(rst_line_o))
    else $error("reset level moved mid pulse");
  reboot_pulse_a: assert property (
    reboot_o |=> !reboot_o) else $error("reboot longer than one cycle");
  reboot_idle_a: assert property (
    reboot_o |-> !rst_line_oe_o && !pwr_oe_o) else $error("line driven at reboot");
  pwr_msg_a: assert property (
    $rose(pwr_oe_o) |-> message_o != 2'h0) else $error("power pulse without message");
endmodule
bind host_power_watchdog_ctrl host_power_watchdog_ctrl_monitor #(.TICK_CYC(TICK_CYC)) mon (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o, .ack_o, .pwr_oe_o, .rst_line_o,
  .rst_line_oe_o, .display_blank_o, .backlight_off_o, .message_o, .reboot_o);
`default_nettype wire

//--- verif/host_board_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_board_model #(
  parameter int PRESS_CYC = 16,
  parameter logic ACTIVE = 1'b1
) (
  input wire logic clk_i,
  input wire logic drv_pwr_i,
  input wire logic drv_pwr_en_i,
  input wire logic drv_rst_i,
  input wire logic drv_rst_en_i,
  output logic pwr_line_o,
  output logic rst_wire_o,
  output logic sense_o
);
  int held = 0;
  logic host_on = 1'b0;
  assign pwr_line_o = drv_pwr_en_i ? drv_pwr_i : 1'b1; // released line pulled up
  assign rst_wire_o = drv_rst_en_i ? drv_rst_i : 1'b1;
  assign sense_o = host_on; // pull-up sense, pulled down while host off
  // power switch toggles host only when pressed at the active level
  always @(posedge clk_i) begin
    held <= (drv_pwr_en_i && drv_pwr_i == ACTIVE) ? held + 1 : 0;
    if (held == PRESS_CYC) host_on <= !host_on;
  end
endmodule
`default_nettype wire

//--- verif/tb_host_power_watchdog_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_host_power_watchdog_ctrl;
  localparam int T = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ur = 1'b0, lr = 1'b0, ok;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack_o, sense, pwr_i, pwr_o, pwr_oe_o, rl_i, rst_line_o, rst_line_oe_o;
  logic blank, bl_off, reboot_o;
  logic [1:0] message_o;
  logic [2:0] watch;
  logic [31:0] expq[$];
  logic [63:0] cmds[4] = '{64'h0208F41C_0001005C, 64'h0000001E_00010F5E,
    64'h0100001D_0001005D, 64'h00000033_000100FF};
  int miscompares = 0, cmp_count = 0, seed = 32'h2A1F, n;
  assign watch = {reboot_o, rst_line_oe_o, pwr_oe_o};
  host_power_watchdog_ctrl #(.TICK_CYC(T)) dut (
    .clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
    .dat_i(dat), .dat_o, .ack_o, .sense_i(sense), .key_ur_i(ur), .key_lr_i(lr),
    .pwr_i, .pwr_o, .pwr_oe_o, .rst_line_i(rl_i), .rst_line_o, .rst_line_oe_o,
    .display_blank_o(blank), .backlight_off_o(bl_off), .message_o, .reboot_o);
  host_board_model brd (.clk_i, .drv_pwr_i(pwr_o), .drv_pwr_en_i(pwr_oe_o),
    .drv_rst_i(rst_line_o), .drv_rst_en_i(rst_line_oe_o), .pwr_line_o(pwr_i),
    .rst_wire_o(rl_i), .sense_o(sense));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    int k;
    k = 0;
    expq.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) begin
      miscompares++;
      stop_test();
    end
    @(posedge clk_i);
  endtask
  // bounded wait for one watched output to reach a level
  task automatic wait_bit(input int b, input logic v, input int lim);
    n = 0;
    ok = 1'b0;
    while (!ok && n < lim) begin
      @(posedge clk_i);
      n++;
      ok = (watch[b] === v);
    end
  endtask
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && expq.size() > 0) check(dat_o, expq.pop_front());
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    foreach (cmds[i]) begin
      wb(1'b1, 8'h00, cmds[i][63:32], 32'h0);
      wb(1'b0, 8'h04, 32'h0, cmds[i][31:0]);
    end
    wb(1'b0, 8'h04, 32'h0, 32'h000000FF);
    wb(1'b1, 8'h08, $random(seed), 32'h0);
    wb(1'b0, 8'h08, 32'h0, 32'h080008F4);
    wb(1'b0, 8'h5C, 32'h0, 32'h000000F4);
    wb(1'b0, 8'h30, 32'h0, 32'h0);
    check(32'({blank, bl_off}), 32'h3);
    $display("test registers done");
    ur <= 1'b1;
    repeat (4 * T) @(posedge clk_i);
    ur <= 1'b0;
    wait_bit(0, 1'b1, 40 * T);
    check(32'(ok), 32'h0);
    ur <= 1'b1;
    wait_bit(0, 1'b1, 12 * T);
    ur <= 1'b0;
    check(32'({ok, pwr_o}), 32'h3);
    check(32'(message_o), 32'(host_power_watchdog_pkg::MSG_POWER_ON));
    wait_bit(0, 1'b0, 12 * T);
    check(32'(n > 7 * T && n <= 9 * T), 32'h1);
    check(32'(watch), 32'h4);
    repeat (6) @(posedge clk_i);
    check(32'(blank), 32'h0);
    $display("test power on done");
    ur <= 1'b1;
    wait_bit(1, 1'b1, 140 * T);
    ur <= 1'b0;
    check(32'({ok, rst_line_o}), 32'h2);
    check(32'(message_o), 32'(host_power_watchdog_pkg::MSG_RESET));
    wait_bit(2, 1'b1, 40 * T);
    check(32'(ok), 32'h1);
    $display("test key reset done");
    wb(1'b1, 8'h00, 32'h0100F71C, 32'h0);
    repeat (3) begin
      wb(1'b1, 8'h00, 32'h0100031D, 32'h0);
      wait_bit(1, 1'b1, 40 * T);
      check(32'(ok), 32'h0);
    end
    wait_bit(1, 1'b1, 100 * T);
    check(32'({ok, rst_line_o}), 32'h2);
    wait_bit(2, 1'b1, 40 * T);
    check(32'(ok), 32'h0);
    wait_bit(1, 1'b1, 110 * T);
    check(32'(ok), 32'h0);
    wb(1'b1, 8'h00, 32'h0100031D, 32'h0);
    wb(1'b0, 8'h60, 32'h0, 32'h00000003);
    wb(1'b1, 8'h00, 32'h0100001D, 32'h0);
    wait_bit(1, 1'b1, 110 * T);
    check(32'(ok), 32'h0);
    $display("test watchdog done");
    wb(1'b1, 8'h00, 32'h0100F41C, 32'h0);
    lr <= 1'b1;
    wait_bit(0, 1'b1, 140 * T);
    check(32'(ok), 32'h1);
    check(32'(message_o), 32'(host_power_watchdog_pkg::MSG_POWER_OFF));
    repeat (12 * T) @(posedge clk_i);
    check(32'(pwr_oe_o), 32'h1);
    lr <= 1'b0;
    wait_bit(0, 1'b0, 3 * T);
    check(32'(ok), 32'h1);
    repeat (6) @(posedge clk_i);
    check(32'(blank), 32'h1);
    $display("test power off done");
    stop_test();
  end
endmodule
`default_nettype wire
